// ---- logic/slow_tick_divider.sv ----
// Divider giving a one-cycle tick per slow oscillator period.
`timescale 1ns/10ps
module slow_tick_divider #(
  parameter int DIVIDE = 750
) (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic resetn_i,
  // Control
  input  wire logic enable_i,
  output logic      tick_o
);

  localparam int W = $clog2(DIVIDE);
  localparam logic [W-1:0] LAST = W'(DIVIDE - 1);

  logic [W-1:0] count;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count  <= '0;
      tick_o <= 1'b0;
    end else if (!enable_i) begin
      count  <= '0;
      tick_o <= 1'b0;
    end else if (count == LAST) begin
      count  <= '0;
      tick_o <= 1'b1;
    end else begin
      count  <= count + W'(1);
      tick_o <= 1'b0;
    end
  end

endmodule : slow_tick_divider

// ---- logic/wake_on_radio_timer.sv ----
// Wake-on-radio sleep timer with classic Wishbone register slave.
`timescale 1ns/10ps
module wake_on_radio_timer #(
  parameter int CRYSTAL_DIV = wor_timer_pkg::CRYSTAL_DIVIDE
) (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Timer events
  output logic             sleep_timeout_value_o,
  output logic             post_wake_delay_select_o,
  output logic             osc_running_o
);

  wor_timer_pkg::wake_ctrl_t  ctrl;
  wor_timer_pkg::wake_state_t state;
  logic [7:0]  timeout_high;
  logic [7:0]  timeout_low;
  logic [15:0] sleep_timeout_value;
  logic [15:0] count_hi;
  logic [14:0] prescale;
  logic [5:0]  delay_count;
  logic [2:0]  cal_count;
  logic        cal_done;
  logic        tick;
  logic        write_strobe;
  logic        osc_on;

  // Register index from byte address
  function automatic logic [7:0] reg_index(input logic [7:0] adr);
    reg_index = {2'h0, adr[7:wor_timer_pkg::ADDR_SHIFT]};
  endfunction : reg_index

  // Prescale terminal count per resolution setting
  function automatic logic [14:0] prescale_last(input logic [1:0] res);
    prescale_last = 15'((32'h1 << (wor_timer_pkg::RES_SHIFT_STEP * res)) - 1);
  endfunction : prescale_last

  assign sleep_timeout_value = {timeout_high, timeout_low};
  assign write_strobe = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  assign osc_on = !ctrl.power_down;

  slow_tick_divider #(
    .DIVIDE (CRYSTAL_DIV)
  ) u_divider (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .enable_i (osc_on),
    .tick_o   (tick)
  );

  // Bus handshake: one wait state, ack drops the cycle after
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // Timeout registers
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timeout_high <= wor_timer_pkg::RST_TIMEOUT_HIGH;
      timeout_low  <= wor_timer_pkg::RST_TIMEOUT_LOW;
    end else if (write_strobe) begin
      if (reg_index(wb_adr_i) == wor_timer_pkg::IDX_TIMEOUT_HIGH) begin
        timeout_high <= wb_dat_i[7:0];
      end
      if (reg_index(wb_adr_i) == wor_timer_pkg::IDX_TIMEOUT_LOW) begin
        timeout_low <= wb_dat_i[7:0];
      end
    end
  end

  // Control register
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl.power_down <= wor_timer_pkg::RST_POWER_DOWN;
      ctrl.delay_sel  <= wor_timer_pkg::RST_DELAY_SEL;
      ctrl.cal_enable <= wor_timer_pkg::RST_CAL_ENABLE;
      ctrl.resolution <= wor_timer_pkg::RST_RESOLUTION;
    end else if (write_strobe && reg_index(wb_adr_i) == wor_timer_pkg::IDX_CONTROL) begin
      ctrl.power_down <= wb_dat_i[wor_timer_pkg::CTL_PD_BIT];
      ctrl.delay_sel  <= wb_dat_i[wor_timer_pkg::CTL_DELAY_HI:wor_timer_pkg::CTL_DELAY_LO];
      ctrl.cal_enable <= wb_dat_i[wor_timer_pkg::CTL_CAL_BIT];
      ctrl.resolution <= wb_dat_i[wor_timer_pkg::CTL_RES_HI:wor_timer_pkg::CTL_RES_LO];
    end
  end

  // Read mux, registered; reserved bits and unmapped addresses read zero
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wb_dat_o <= 32'h0;
    end else if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) begin
      wb_dat_o <= 32'h0;
      case (reg_index(wb_adr_i))
        wor_timer_pkg::IDX_TIMEOUT_HIGH: begin
          wb_dat_o[7:0] <= timeout_high;
        end
        wor_timer_pkg::IDX_TIMEOUT_LOW: begin
          wb_dat_o[7:0] <= timeout_low;
        end
        wor_timer_pkg::IDX_CONTROL: begin
          wb_dat_o[wor_timer_pkg::CTL_PD_BIT] <= ctrl.power_down;
          wb_dat_o[wor_timer_pkg::CTL_DELAY_HI:wor_timer_pkg::CTL_DELAY_LO] <= ctrl.delay_sel;
          wb_dat_o[wor_timer_pkg::CTL_CAL_BIT] <= ctrl.cal_enable;
          wb_dat_o[wor_timer_pkg::CTL_RES_HI:wor_timer_pkg::CTL_RES_LO] <= ctrl.resolution;
        end
        wor_timer_pkg::IDX_STATUS: begin
          wb_dat_o[wor_timer_pkg::STS_RUN_BIT]  <= osc_running_o;
          wb_dat_o[wor_timer_pkg::STS_CAL_BIT]  <= (state == wor_timer_pkg::ST_CAL);
          wb_dat_o[wor_timer_pkg::STS_DONE_BIT] <= cal_done;
        end
        default: begin
          wb_dat_o <= 32'h0;
        end
      endcase
    end
  end

  // Sequencer: calibrate, sleep (Event 0), delay (Event 1), repeat
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state         <= wor_timer_pkg::ST_OFF;
      count_hi      <= 16'h0;
      prescale      <= 15'h0;
      delay_count   <= 6'h0;
      cal_count     <= 3'h0;
      cal_done      <= 1'b0;
      sleep_timeout_value_o      <= 1'b0;
      post_wake_delay_select_o      <= 1'b0;
      osc_running_o <= 1'b0;
    end else begin
      sleep_timeout_value_o      <= 1'b0;
      post_wake_delay_select_o      <= 1'b0;
      osc_running_o <= osc_on;
      if (!osc_on) begin
        state    <= wor_timer_pkg::ST_OFF;
        cal_done <= 1'b0;
      end else begin
        case (state)
          wor_timer_pkg::ST_OFF: begin
            // Power-up always runs the initial calibration
            cal_count <= 3'h0;
            state     <= wor_timer_pkg::ST_CAL;
          end
          wor_timer_pkg::ST_CAL: begin
            if (tick) begin
              cal_count <= cal_count + 3'h1;
              if (cal_count == 3'(wor_timer_pkg::CAL_TICKS - 1)) begin
                cal_done <= 1'b1;
                count_hi <= 16'h0;
                prescale <= 15'h0;
                state    <= wor_timer_pkg::ST_SLEEP;
              end
            end
          end
          wor_timer_pkg::ST_SLEEP: begin
            if (tick) begin
              if (prescale == prescale_last(ctrl.resolution)) begin
                prescale <= 15'h0;
                // Zero timeout behaves as one count, never stalls
                if (count_hi + 16'h1 >= sleep_timeout_value) begin
                  sleep_timeout_value_o    <= 1'b1;
                  delay_count <= 6'h0;
                  state       <= wor_timer_pkg::ST_DELAY;
                end else begin
                  count_hi <= count_hi + 16'h1;
                end
              end else begin
                prescale <= prescale + 15'h1;
              end
            end
          end
          wor_timer_pkg::ST_DELAY: begin
            if (tick) begin
              // Select may change mid-delay: end at once rather than wrap
              if (delay_count + 6'h1 >= wor_timer_pkg::DELAY_TABLE[ctrl.delay_sel]) begin
                post_wake_delay_select_o <= 1'b1;
                count_hi <= 16'h0;
                prescale <= 15'h0;
                // Periodic recalibration when enabled
                if (ctrl.cal_enable) begin
                  cal_count <= 3'h0;
                  state     <= wor_timer_pkg::ST_CAL;
                end else begin
                  state <= wor_timer_pkg::ST_SLEEP;
                end
              end else begin
                delay_count <= delay_count + 6'h1;
              end
            end
          end
          default: begin
            state <= wor_timer_pkg::ST_OFF;
          end
        endcase
      end
    end
  end

endmodule : wake_on_radio_timer

// ---- logic/wor_timer_pkg.sv ----
// Package for the wake-on-radio sleep timer: register map, fields, constants.
package wor_timer_pkg;

  // Register word indices (printed offsets are not all multiples of four)
  localparam logic [7:0] IDX_TIMEOUT_HIGH = 8'h1e;
  localparam logic [7:0] IDX_TIMEOUT_LOW  = 8'h1f;
  localparam logic [7:0] IDX_CONTROL      = 8'h20;
  localparam logic [7:0] IDX_STATUS       = 8'h21;
  localparam int         ADDR_SHIFT       = 2;

  // Reset values
  localparam logic [7:0] RST_TIMEOUT_HIGH = 8'h87;
  localparam logic [7:0] RST_TIMEOUT_LOW  = 8'h6b;
  localparam logic       RST_POWER_DOWN   = 1'b1;
  localparam logic [2:0] RST_DELAY_SEL    = 3'h7;
  localparam logic       RST_CAL_ENABLE   = 1'b1;
  localparam logic [1:0] RST_RESOLUTION   = 2'h0;

  // Control register field positions
  localparam int CTL_PD_BIT    = 7;
  localparam int CTL_DELAY_HI  = 6;
  localparam int CTL_DELAY_LO  = 4;
  localparam int CTL_CAL_BIT   = 3;
  localparam int CTL_RES_HI    = 1;
  localparam int CTL_RES_LO    = 0;

  // Status register field positions
  localparam int STS_RUN_BIT   = 0;
  localparam int STS_CAL_BIT   = 1;
  localparam int STS_DONE_BIT  = 2;

  // Timing
  localparam int CRYSTAL_DIVIDE   = 750;
  localparam int RES_SHIFT_STEP   = 5;
  localparam int CAL_TICKS        = 4;

  // Event 1 delay table, in slow-clock periods
  localparam logic [5:0] DELAY_TABLE [8] = '{6'h04, 6'h06, 6'h08, 6'h0c,
                                              6'h10, 6'h18, 6'h20, 6'h30};

  typedef struct packed {
    logic       power_down;
    logic [2:0] delay_sel;
    logic       cal_enable;
    logic [1:0] resolution;
  } wake_ctrl_t;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_CAL,
    ST_SLEEP,
    ST_DELAY
  } wake_state_t;

endpackage : wor_timer_pkg

// ---- testbench/testbench.sv ----
// Self-checking bench for the wake-on-radio timer.
`timescale 1ns/10ps
module testbench;
  localparam int DIV = 4;
  localparam int DLY [8] = '{4, 6, 8, 12, 16, 24, 32, 48};
  logic        clock_i  = 1'b0;
  logic        resetn_i = 1'b0;
  logic        cyc      = 1'b0;
  logic        stb      = 1'b0;
  logic        we       = 1'b0;
  logic [7:0]  adr      = 8'h0;
  logic [3:0]  sel      = 4'h0;
  logic [31:0] wdat     = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        ev0;
  logic        ev1;
  logic        run;
  int          n_errors = 0;
  int          compares = 0;
  int          cycles   = 0;
  int          n;
  always #5 clock_i = ~clock_i;
  wake_on_radio_timer #(.CRYSTAL_DIV(DIV)) dut (
    .clock_i, .resetn_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sleep_timeout_value_o(ev0),
    .post_wake_delay_select_o(ev1), .osc_running_o(run));
  task end_sim;
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  // Cut a hang short well after the expected run length
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      end_sim();
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One classic cycle; request held until ack is sampled high
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
           output logic [31:0] q);
    @(posedge clock_i);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, 24'h0, d};
    do @(posedge clock_i); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb, we} <= 3'b000;
  endtask : bus
  task wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1);
    logic [31:0] q;
    bus(1'b1, a, d, s, q);
  endtask : wr
  task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h0, 4'hf, q);
    chk(nm, e, q);
  endtask : rd
  // Counts cycles until the chosen event pulses
  task wev(input logic which, output int k);
    k = 0;
    do begin
      @(posedge clock_i);
      #1;
      k++;
    end while ((which ? ev1 : ev0) !== 1'b1);
  endtask : wev
  initial begin
    repeat (10) @(posedge clock_i);
    resetn_i <= 1'b1;
    rd("high", 8'h78, 32'h87);
    rd("low", 8'h7c, 32'h6b);
    rd("ctrl", 8'h80, 32'hf8);
    rd("unmapped", 8'h88, 32'h0);
    wr(8'h78, 8'h55, 4'h2);
    rd("high no sel", 8'h78, 32'h87);
    wr(8'h78, 8'h00);
    wr(8'h7c, 8'h02);
    rd("low", 8'h7c, 32'h02);
    wr(8'h80, 8'hff);
    rd("ctrl reserved", 8'h80, 32'hfb);
    chk("osc off", 32'h0, {31'h0, run});
    // Every delay code, calibration off, resolution 0
    for (int i = 0; i < 8; i++) begin
      wr(8'h80, 8'(i << 4));
      wev(1'b0, n);
      wev(1'b1, n);
      chk("post_wake_delay_select delay", DLY[i] * DIV, n);
      wev(1'b0, n);
      chk("sleep_timeout_value period", 2 * DIV, n);
    end
    chk("osc on", 32'h1, {31'h0, run});
    rd("status on", 8'h84, 32'h5);
    wr(8'h80, 8'h01);
    wev(1'b1, n);
    wev(1'b0, n);
    chk("res1 period", 2 * 32 * DIV, n);
    wr(8'h80, 8'h08);
    wev(1'b1, n);
    wev(1'b0, n);
    chk("cal period", (4 + 2) * DIV, n);
    wr(8'h7c, 8'h01);
    wr(8'h80, 8'h02);
    wev(1'b1, n);
    wev(1'b0, n);
    chk("res2 period", 1024 * DIV, n);
    wr(8'h80, 8'h80);
    repeat (2) @(posedge clock_i);
    chk("osc stopped", 32'h0, {31'h0, run});
    rd("status off", 8'h84, 32'h0);
    end_sim();
  end
endmodule : testbench

// ---- testbench/wor_timer_assertions.sv ----
// Port checker for the wake-on-radio timer.
`timescale 1ns/10ps
module wor_timer_assertions #(
  parameter int CRYSTAL_DIV = 750
) (
  // Clock, reset and bus
  input wire logic        clock_i,
  input wire logic        resetn_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Events
  input wire logic        sleep_timeout_value_o,
  input wire logic        post_wake_delay_select_o,
  input wire logic        osc_running_o
);
  // Cycles since the last Event 0, saturating
  logic [15:0] gap;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) gap <= 16'h0;
    else if (sleep_timeout_value_o) gap <= 16'h1;
    else if (gap != 16'hffff) gap <= gap + 16'h1;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ctl_wr;
    wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h80;
  endsequence
  AST_ACK: assert property (s_req |=> wb_ack_o) else $error("no ack");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  AST_DAT_HI: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  AST_PD_ON: assert property (s_ctl_wr ##0 !wb_dat_i[7] |=> osc_running_o)
    else $error("oscillator not started");
  AST_PD_OFF: assert property (s_ctl_wr ##0 wb_dat_i[7] |=> !osc_running_o)
    else $error("oscillator not stopped");
  AST_EV0_PULSE: assert property (sleep_timeout_value_o |=> !sleep_timeout_value_o) else $error("long sleep_timeout_value");
  AST_EV1_PULSE: assert property (post_wake_delay_select_o |=> !post_wake_delay_select_o [*8]) else $error("post_wake_delay_select repeat");
  AST_EV1_GAP: assert property (post_wake_delay_select_o |-> gap >= 4 * CRYSTAL_DIV &&
    gap <= 48 * CRYSTAL_DIV && gap % CRYSTAL_DIV == 0) else $error("post_wake_delay_select spacing");
  AST_OFF_QUIET: assert property (!osc_running_o && !$past(osc_running_o)
    |-> !sleep_timeout_value_o && !post_wake_delay_select_o) else $error("event while powered down");
endmodule : wor_timer_assertions

bind wake_on_radio_timer wor_timer_assertions #(.CRYSTAL_DIV(CRYSTAL_DIV)) u_chk (
  .clock_i, .resetn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .sleep_timeout_value_o, .post_wake_delay_select_o, .osc_running_o);
